/* bcrf_chk.sv */
// Checker of bank and swap outputs against completed bus writes
`timescale 1ns/1ps
module bcrf_chk
   import bcrf_pkg::*;
(
   // Clock, reset and bus
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Status outputs
   input wire logic [2:0]  active_bank,
   input wire logic        register_set_swap
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // Completed transfers and what may move the outputs
   wire done_wr = avs_write && !avs_waitrequest;
   wire psw_wr = done_wr && avs_address == OFS_STATUS[3:0];
   wire ctx_wr = done_wr && avs_address == OFS_CTXSW[3:0];
   wire bank_cause = psw_wr || ctx_wr;
   wire swap_cause = bank_cause || (done_wr && avs_address == OFS_CTRL[3:0]);
   wire psw_rd = avs_read && !avs_waitrequest && avs_address == OFS_STATUS[3:0];
   // Bank select through the context port, no pop
   sequence s_sel_bank;
      ctx_wr && avs_writedata[0] && !avs_writedata[1];
   endsequence
   property p_bank_reset;
      $fell(srst) |-> active_bank == 3'h0 && !register_set_swap;
   endproperty
   a_bank_reset: assert property (p_bank_reset) else $error("bank not zero after reset");
   property p_bank_write;
      psw_wr |=> active_bank == $past(avs_writedata[10:8]);
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("bank differs from status");
   property p_swap_write;
      psw_wr |=> register_set_swap == $past(avs_writedata[5]);
   endproperty
   a_swap_write: assert property (p_swap_write) else $error("swap differs from status");
   property p_ctx_bank;
      s_sel_bank |=> active_bank == $past(avs_writedata[10:8]);
   endproperty
   a_ctx_bank: assert property (p_ctx_bank) else $error("context bank select lost");
   property p_bank_hold;
      !$stable(active_bank) && !$past(srst) |-> $past(bank_cause);
   endproperty
   a_bank_hold: assert property (p_bank_hold) else $error("bank moved on its own");
   property p_swap_hold;
      !$stable(register_set_swap) && !$past(srst) |-> $past(swap_cause);
   endproperty
   a_swap_hold: assert property (p_swap_hold) else $error("swap moved on its own");
   property p_psw_read;
      psw_rd |-> avs_readdata[10:8] == active_bank && avs_readdata[5] == register_set_swap;
   endproperty
   a_psw_read: assert property (p_psw_read) else $error("status read disagrees");
   property p_save_keeps;
      ctx_wr && avs_writedata[3:0] == 4'h8 |=> $stable(active_bank);
   endproperty
   a_save_keeps: assert property (p_save_keeps) else $error("save switched bank");
endmodule // bcrf_chk

bind bcrf_top bcrf_chk u_chk (.mclk(mclk), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .active_bank(active_bank), .register_set_swap(register_set_swap));

/* bcrf_cpu_model.sv */
// Bus-master model of the execution logic driving the register file
`timescale 1ns/1ps
module bcrf_cpu_model (
   // Clock
   input wire logic        mclk,
   // Avalon-MM master
   output logic [3:0]      avs_address,
   output logic            avs_read,
   output logic            avs_write,
   output logic [31:0]     avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   // Idle bus from time zero
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // Write held until waitrequest is sampled low; data inverted once released
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_writedata <= ~d;
   endtask
   // Read taken at the edge where waitrequest is sampled low
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
endmodule // bcrf_cpu_model

/* bcrf_pkg.sv */
// Package for the banked CPU register file: bus map, field layouts, constants
package bcrf_pkg;

   // Avalon-MM word offsets (byte address = 4 * index)
   localparam logic [7:0] OFS_CTRL     = 8'h00; // Swap flag, location mode
   localparam logic [7:0] OFS_STATUS   = 8'h01; // Status word (bank in bits 8..10)
   localparam logic [7:0] OFS_SP       = 8'h02; // System stack pointer
   localparam logic [7:0] OFS_NAMESEL  = 8'h03; // Operand selector
   localparam logic [7:0] OFS_NAMEDATA = 8'h04; // Operand data through selector
   localparam logic [7:0] OFS_STACK    = 8'h05; // Stack push/pop port
   localparam logic [7:0] OFS_CTXSW    = 8'h06; // Context switch / return trigger
   localparam logic [7:0] OFS_PC       = 8'h07; // Program counter image
   localparam logic [7:0] OFS_RAMWIN   = 8'h08; // Memory address for RAM alias
   localparam logic [7:0] OFS_RAMDATA  = 8'h09; // Memory data through alias
   localparam logic [7:0] OFS_ROLE     = 8'h0A; // Dedicated role view select
   localparam logic [7:0] OFS_ROLEDATA = 8'h0B; // Dedicated role data

   // Control fields
   localparam int CTRL_SWAP_BIT = 0;
   localparam int CTRL_LOC_BIT  = 1;

   // Status word layout: bank bits 8..10 of a 16-bit word
   localparam int BANK_LO_BIT  = 8;
   localparam int BANK_HI_BIT  = 10;
   localparam int SWAP_BIT_PSW = 5;
   localparam logic [15:0] PSW_RESET = 16'h0000;
   localparam logic [15:0] PSW_CTX_MASK = 16'hF0FF; // Excludes high byte bits 0..3

   // RAM alias windows
   localparam logic [23:0] RAM_LO_BASE = 24'h00FE80;
   localparam logic [23:0] RAM_HI_BASE = 24'h0FFE80;
   localparam logic [23:0] RAM_SIZE    = 24'h000080;

   // Geometry
   localparam int NUM_BANKS = 8;
   localparam int REGS_PER_BANK = 16;

   // Operand kinds in the selector
   typedef enum logic [2:0] {
      BCRF_ABS8  = 3'b000, // Absolute 8-bit register 0..15
      BCRF_ABS16 = 3'b001, // Absolute pair 0..7
      BCRF_ABS24 = 3'b010, // Absolute 24-bit 4..7
      BCRF_FN8   = 3'b011, // Function name 8-bit: 0=X 1=A 2=C 3=B
      BCRF_FN16  = 3'b100, // Function name pair: 0=AX 1=BC
      BCRF_IDX   = 3'b101  // Index offset: 0=A 1=B 2=C
   } bcrf_kind_t;

   // Role views
   typedef enum logic [2:0] {
      BCRF_ROLE_LOOP_B  = 3'b000,
      BCRF_ROLE_LOOP_C  = 3'b001,
      BCRF_ROLE_STRPTR1 = 3'b010,
      BCRF_ROLE_STRPTR2 = 3'b011,
      BCRF_ROLE_USP     = 3'b100,
      BCRF_ROLE_WIDE    = 3'b101
   } bcrf_role_t;

   typedef struct packed {
      bcrf_kind_t kind;
      logic [3:0] num;
   } bcrf_opsel_t;

endpackage

/* bcrf_top.sv */
// Banked CPU register file with stack pointer, Avalon-MM slave
// Operation
// - Swap flag moves X,A,C,B,AX,BC onto registers 4..7 and pairs 2,3.
// - Absolute register numbers always select the physical register.
// - Index offsets only via aliased names A, B, C.
// - Stack pointer is a 24-bit register addressing the stack.
// - Pre-decrement before stack write, post-increment after stack read.
// - Sixteen 8-bit registers per bank; adjacent pairs form 16-bit registers.
// - Four pairs extend with an 8-bit register into 24-bit registers.
// - All but the extension registers live in RAM; extensions separate.
// - Eight banks, switched by software or context switching.
// - Reset selects bank 0; bank readable in status word bits.
// - Register RAM also visible as data memory in low or high window.
// - Interrupt pushes status word; returns restore it.
// - Context switch saves low 16 PC bits into pair 2.
// - Context switch saves upper PC bits and status word bits 0..7 and 12..15 into pair 3.
// - Registers 3 and 2 serve as loop counters B and C.
// - Register 2 counts elements; 24-bit 6 and 7 act as pointers.
// - 24-bit register 5 is the user stack pointer.
// - Pairs 0 and 6 form a 32-bit wide operand.
// - Every register addressable by absolute 8, 16 or 24-bit number.
// - Bank bits encode the active bank in plain binary.
`timescale 1ns/1ps
module bcrf_top
   import bcrf_pkg::*;
#(
   parameter int STACK_WORDS = 16
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Status outputs
   output logic [2:0]       active_bank,
   output logic             register_set_swap
);

   // Register RAM: 8 banks x 16 bytes, plus separate extension bytes
   logic [7:0]  reg_ram [0:NUM_BANKS*REGS_PER_BANK-1];
   logic [7:0]  ext_reg [0:NUM_BANKS*4-1];
   logic [7:0]  stack_mem [0:STACK_WORDS-1];
   logic [15:0] processor_status_word;
   logic [23:0] system_stack_pointer;
   logic [19:0] pc_image;
   logic        loc_high;
   bcrf_opsel_t opsel;
   bcrf_role_t  role_sel;
   logic [23:0] ram_addr;
   logic        ack;
   logic [31:0] rdata;

   // Single-cycle wait then acknowledge
   // The first cycle of a request always waits; ack rises at the edge that
   // ends it, so the second cycle shows waitrequest low and the transfer
   // completes at the edge that ends the second cycle.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   wire   req_go = (avs_read | avs_write) & ack;
   wire   wr_go  = avs_write & ack;
   wire   rd_go  = avs_read & ack;

   wire [2:0] bank = processor_status_word[BANK_HI_BIT:BANK_LO_BIT];
   assign active_bank = bank;
   assign register_set_swap = processor_status_word[SWAP_BIT_PSW];

   // Byte index of register r in bank b
   function automatic logic [6:0] ridx(input logic [2:0] b, input logic [3:0] r);
      ridx = {b, r};
   endfunction

   // Map selector to first absolute 8-bit register and width in bytes
   function automatic logic [5:0] resolve(input bcrf_opsel_t s, input logic sw);
      logic [3:0] r;
      logic [1:0] w;
      r = 4'h0;
      w = 2'd1;
      case (s.kind)
         // Absolute names ignore the swap flag
         BCRF_ABS8: begin
            r = s.num;
            w = 2'd1;
         end
         BCRF_ABS16: begin
            r = {s.num[2:0], 1'b0};
            w = 2'd2;
         end
         // 24-bit 4..7 sit on pairs 4..7, that is bytes 8..15
         BCRF_ABS24: begin
            r = {1'b1, s.num[1:0], 1'b0};
            w = 2'd3;
         end
         // Function names move up by four when the swap flag is set
         BCRF_FN8: begin
            r = {1'b0, sw, s.num[1:0]};
            w = 2'd1;
         end
         BCRF_FN16: begin
            r = {1'b0, sw, s.num[0], 1'b0};
            w = 2'd2;
         end
         // Offsets exist only as aliased names, never as raw numbers
         BCRF_IDX: begin
            case (s.num[1:0])
               2'd0:    r = {1'b0, sw, 2'b01};
               2'd1:    r = {1'b0, sw, 2'b11};
               default: r = {1'b0, sw, 2'b10};
            endcase
            w = 2'd1;
         end
         default: begin
            r = 4'h0;
            w = 2'd1;
         end
      endcase
      resolve = {r, w};
   endfunction

   wire [5:0] res    = resolve(opsel, register_set_swap);
   wire [3:0] sel_r  = res[5:2];
   wire [1:0] sel_w  = res[1:0];
   wire [1:0] sel_g  = sel_r[2:1]; // 24-bit group index 4..7 -> 0..3

   // Role views to absolute registers
   wire [3:0] role_r = (role_sel == BCRF_ROLE_LOOP_B) ? 4'd3 :
                       (role_sel == BCRF_ROLE_LOOP_C) ? 4'd2 :
                       (role_sel == BCRF_ROLE_STRPTR1) ? 4'd12 :
                       (role_sel == BCRF_ROLE_STRPTR2) ? 4'd14 :
                       (role_sel == BCRF_ROLE_USP) ? 4'd10 : 4'd0;
   wire role_24 = (role_sel == BCRF_ROLE_STRPTR1) | (role_sel == BCRF_ROLE_STRPTR2) |
                  (role_sel == BCRF_ROLE_USP);
   wire role_32 = (role_sel == BCRF_ROLE_WIDE);

   // RAM alias decode for both location modes
   wire [23:0] ram_base = loc_high ? RAM_HI_BASE : RAM_LO_BASE;
   wire [23:0] ram_off  = ram_addr - ram_base;
   wire        ram_hit  = (ram_addr >= ram_base) && (ram_off < RAM_SIZE);
   wire [6:0]  ram_idx  = ram_off[6:0];

   // Stack slot for pre-decremented pointer and for current pointer
   wire [23:0] sp_dec   = system_stack_pointer - 24'h000001;
   localparam int SW = $clog2(STACK_WORDS);
   wire [SW-1:0] slot_push = sp_dec[SW-1:0];
   wire [SW-1:0] slot_pop  = system_stack_pointer[SW-1:0];

   wire [2:0] wbank = bank;

   // Read a general register of the active bank
   function automatic logic [7:0] rd8(input logic [3:0] r);
      rd8 = reg_ram[ridx(wbank, r)];
   endfunction

   // Read mux
   always_comb begin
      rdata = 32'h0000_0000;
      case (avs_address)
         OFS_CTRL[3:0]:    rdata = {30'h0, loc_high, register_set_swap};
         OFS_STATUS[3:0]:  rdata = {16'h0000, processor_status_word};
         OFS_SP[3:0]:      rdata = {8'h00, system_stack_pointer};
         OFS_NAMESEL[3:0]: rdata = {25'h0, opsel};
         OFS_NAMEDATA[3:0]: begin
            if (sel_w == 2'd1)
               rdata = {24'h0, rd8(sel_r)};
            else if (sel_w == 2'd2)
               rdata = {16'h0, rd8(sel_r + 4'd1), rd8(sel_r)};
            else
               rdata = {8'h0, ext_reg[{wbank, sel_g}], rd8(sel_r + 4'd1), rd8(sel_r)};
         end
         OFS_STACK[3:0]:   rdata = {24'h0, stack_mem[slot_pop]};
         OFS_PC[3:0]:      rdata = {12'h0, pc_image};
         OFS_RAMWIN[3:0]:  rdata = {8'h00, ram_addr};
         OFS_RAMDATA[3:0]: rdata = ram_hit ? {24'h0, reg_ram[ram_idx]} : 32'h0;
         OFS_ROLE[3:0]:    rdata = {29'h0, role_sel};
         OFS_ROLEDATA[3:0]: begin
            if (role_32)
               rdata = {rd8(4'd13), rd8(4'd12), rd8(4'd1), rd8(4'd0)};
            else if (role_24)
               rdata = {8'h0, ext_reg[{wbank, role_r[2:1]}], rd8(role_r + 4'd1), rd8(role_r)};
            else
               rdata = {24'h0, rd8(role_r)};
         end
         default:          rdata = 32'h0000_0000;
      endcase
   end

   // Acknowledge handshake and read data register
   always_ff @(posedge mclk) begin
      if (srst) begin
         ack          <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack          <= (avs_read | avs_write) & ~ack;
         // Capture in the wait cycle: the data then already stand at the
         // edge where the master sees waitrequest low and takes them
         if (avs_read & ~ack)
            avs_readdata <= rdata;
      end
   end

   // Control, status, selector, role, PC and RAM window state
   always_ff @(posedge mclk) begin
      if (srst) begin
         processor_status_word <= PSW_RESET;
         loc_high  <= 1'b0;
         opsel     <= '{kind: BCRF_ABS8, num: 4'h0};
         role_sel  <= BCRF_ROLE_LOOP_B;
         ram_addr  <= 24'h000000;
         pc_image  <= 20'h00000;
      end else if (wr_go) begin
         case (avs_address)
            OFS_CTRL[3:0]: begin
               processor_status_word[SWAP_BIT_PSW] <= avs_writedata[CTRL_SWAP_BIT];
               loc_high <= avs_writedata[CTRL_LOC_BIT];
            end
            OFS_STATUS[3:0]:  processor_status_word <= avs_writedata[15:0];
            OFS_NAMESEL[3:0]: opsel <= bcrf_opsel_t'(avs_writedata[6:0]);
            OFS_PC[3:0]:      pc_image <= avs_writedata[19:0];
            OFS_RAMWIN[3:0]:  ram_addr <= avs_writedata[23:0];
            OFS_ROLE[3:0]:    role_sel <= bcrf_role_t'(avs_writedata[2:0]);
            OFS_CTXSW[3:0]: begin
               // Bit 1 restores a pushed status word; bit 0 switches bank
               if (avs_writedata[1])
                  processor_status_word <= {stack_mem[slot_pop], stack_mem[slot_pop + SW'(1)]};
               else if (avs_writedata[0])
                  processor_status_word[BANK_HI_BIT:BANK_LO_BIT] <= avs_writedata[10:8];
            end
            default: ;
         endcase
      end
   end

   // Stack pointer: no reset, software must load it first
   always_ff @(posedge mclk) begin
      if (wr_go && avs_address == OFS_SP[3:0])
         system_stack_pointer <= avs_writedata[23:0];
      else if (wr_go && avs_address == OFS_STACK[3:0])
         system_stack_pointer <= sp_dec;
      else if (rd_go && avs_address == OFS_STACK[3:0])
         system_stack_pointer <= system_stack_pointer + 24'h000001;
      else if (wr_go && avs_address == OFS_CTXSW[3:0] && avs_writedata[2])
         system_stack_pointer <= system_stack_pointer - 24'h000002;
      else if (wr_go && avs_address == OFS_CTXSW[3:0] && avs_writedata[1])
         system_stack_pointer <= system_stack_pointer + 24'h000002;
   end

   // Stack memory: push bytes and interrupt status word pushes
   always_ff @(posedge mclk) begin
      if (wr_go && avs_address == OFS_STACK[3:0])
         stack_mem[slot_push] <= avs_writedata[7:0];
      else if (wr_go && avs_address == OFS_CTXSW[3:0] && avs_writedata[2]) begin
         stack_mem[slot_push] <= processor_status_word[7:0];
         stack_mem[slot_push - SW'(1)] <= processor_status_word[15:8];
      end
   end

   // Register RAM writes: name port, RAM alias and context save share storage
   wire [2:0] nbank = avs_writedata[10:8];
   wire [15:0] ctx_psw = processor_status_word & PSW_CTX_MASK;
   always_ff @(posedge mclk) begin
      if (wr_go && avs_address == OFS_NAMEDATA[3:0]) begin
         reg_ram[ridx(wbank, sel_r)] <= avs_writedata[7:0];
         if (sel_w != 2'd1)
            reg_ram[ridx(wbank, sel_r + 4'd1)] <= avs_writedata[15:8];
      end else if (wr_go && avs_address == OFS_ROLEDATA[3:0]) begin
         reg_ram[ridx(wbank, role_r)] <= avs_writedata[7:0];
         if (role_24 | role_32)
            reg_ram[ridx(wbank, role_r + 4'd1)] <= avs_writedata[15:8];
         // Wide operand upper half lives in bytes 12 and 13
         if (role_32) begin
            reg_ram[ridx(wbank, 4'd12)] <= avs_writedata[23:16];
            reg_ram[ridx(wbank, 4'd13)] <= avs_writedata[31:24];
         end
      end else if (wr_go && avs_address == OFS_RAMDATA[3:0] && ram_hit)
         reg_ram[ram_idx] <= avs_writedata[7:0];
      else if (wr_go && avs_address == OFS_CTXSW[3:0] && avs_writedata[3]) begin
         // Save into the new bank's pairs 2 and 3
         reg_ram[ridx(nbank, 4'd4)] <= pc_image[7:0];
         reg_ram[ridx(nbank, 4'd5)] <= pc_image[15:8];
         reg_ram[ridx(nbank, 4'd6)] <= ctx_psw[7:0];
         reg_ram[ridx(nbank, 4'd7)] <= {pc_image[19:16], ctx_psw[11:8] | ctx_psw[15:12]};
      end
   end

   // Extension registers, held apart from the RAM
   always_ff @(posedge mclk) begin
      if (wr_go && avs_address == OFS_NAMEDATA[3:0] && sel_w == 2'd3)
         ext_reg[{wbank, sel_g}] <= avs_writedata[23:16];
      else if (wr_go && avs_address == OFS_ROLEDATA[3:0] && role_24)
         ext_reg[{wbank, role_r[2:1]}] <= avs_writedata[23:16];
   end

   wire unused_ok = req_go;

endmodule // bcrf_top

/* tb_top.sv */
// Self-checking bench for the banked register file
`timescale 1ns/1ps
module tb_top;
   import bcrf_pkg::*;
   // Bus and status nets
   logic        mclk;
   logic        srst;
   logic [3:0]  addr;
   logic        rd_en;
   logic        wr_en;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wait_req;
   logic [2:0]  bank;
   logic        swap;
   // Bench state
   int          failures;
   int          checks;
   int          cycles;
   int          seed;
   logic [7:0]  regs [16];
   logic [31:0] rv;
   logic [31:0] d;
   logic [3:0]  p;

   bcrf_top #(.STACK_WORDS(16)) u_dut (.mclk(mclk), .srst(srst), .avs_address(addr),
      .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .active_bank(bank), .register_set_swap(swap));
   bcrf_cpu_model u_cpu (.mclk(mclk), .avs_address(addr), .avs_read(rd_en),
      .avs_write(wr_en), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_req));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Operand access through the selector
   task automatic sel_rd(bcrf_kind_t k, logic [3:0] n);
      u_cpu.wr(OFS_NAMESEL[3:0], {25'h0, k, n});
      u_cpu.rd(OFS_NAMEDATA[3:0], rv);
   endtask
   // Physical register behind a function name or index offset
   function automatic logic [3:0] phys(logic sw, logic [3:0] n, logic idx);
      logic [3:0] b;
      b = idx ? ((n == 4'h0) ? 4'h1 : (n == 4'h1) ? 4'h3 : 4'h2) : n;
      return sw ? b + 4'h4 : b;
   endfunction

   // Main sequence
   initial begin
      seed = 6489;
      failures = 0;
      checks = 0;
      cycles = 0;
      srst = 1'b1;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      u_cpu.rd(OFS_STATUS[3:0], rv);
      chk("status", rv[15:0], PSW_RESET);
      chk("bank", bank, 0);
      for (int b = 0; b < 8; b++) begin
         u_cpu.wr(OFS_STATUS[3:0], {21'h0, b[2:0], 8'h00});
         u_cpu.rd(OFS_STATUS[3:0], rv);
         chk("bank", bank, b);
      end
      $display("test reset and banks done");
      u_cpu.wr(OFS_STATUS[3:0], 32'h0600);
      for (int r = 0; r < 16; r++) begin
         d = $random(seed);
         regs[r] = d[7:0];
         u_cpu.wr(OFS_NAMESEL[3:0], {25'h0, BCRF_ABS8, r[3:0]});
         u_cpu.wr(OFS_NAMEDATA[3:0], {24'h0, regs[r]});
      end
      for (int q = 0; q < 8; q++) begin
         sel_rd(BCRF_ABS16, q[3:0]);
         chk("pair", rv[15:0], {regs[2*q+1], regs[2*q]});
      end
      for (int q = 0; q < 4; q++) begin
         sel_rd(BCRF_ABS24, q[3:0]);
         chk("reg24", rv[15:0], {regs[2*q+9], regs[2*q+8]});
      end
      u_cpu.wr(OFS_NAMESEL[3:0], {25'h0, BCRF_ABS24, 4'h3});
      u_cpu.wr(OFS_NAMEDATA[3:0], {8'h0, 8'hA5, regs[15], regs[14]});
      sel_rd(BCRF_ABS24, 4'h3);
      chk("reg24 ext", rv, {8'h0, 8'hA5, regs[15], regs[14]});
      for (int q = 0; q < 3; q++) begin
         p = (q == 2) ? 4'h5 : q[3:0];
         u_cpu.wr(OFS_ROLE[3:0], {28'h0, p});
         u_cpu.rd(OFS_ROLEDATA[3:0], rv);
         d = (q == 2) ? {regs[13], regs[12], regs[1], regs[0]} : {24'h0, regs[3-q]};
         chk("role", (q == 2) ? rv : {24'h0, rv[7:0]}, d);
      end
      for (int q = 2; q < 5; q++) begin
         u_cpu.wr(OFS_ROLE[3:0], {28'h0, q[3:0]});
         u_cpu.rd(OFS_ROLEDATA[3:0], rv);
         p = (q == 4) ? 4'h5 : 4'(q + 4);
         chk("role24", rv[15:0], {regs[2*p+1], regs[2*p]});
      end
      d = $random(seed);
      u_cpu.wr(OFS_ROLE[3:0], 32'h5);
      u_cpu.wr(OFS_ROLEDATA[3:0], d);
      {regs[13], regs[12], regs[1], regs[0]} = d;
      sel_rd(BCRF_ABS16, 4'h6);
      chk("wide hi", rv[15:0], d[31:16]);
      $display("test absolute names done");
      for (int sw = 0; sw < 2; sw++) begin
         u_cpu.wr(OFS_STATUS[3:0], {26'h0018, sw[0], 5'h0});
         for (int n = 0; n < 4; n++) begin
            sel_rd(BCRF_FN8, n[3:0]);
            chk("fn8", rv[7:0], regs[phys(sw[0], n[3:0], 1'b0)]);
            sel_rd(BCRF_IDX, n[3:0] % 4'h3);
            chk("index", rv[7:0], regs[phys(sw[0], n[3:0] % 4'h3, 1'b1)]);
            p = 4'(2 * sw + n % 2);
            sel_rd(BCRF_FN16, 4'(n % 2));
            chk("fn16", rv[15:0], {regs[2*p+1], regs[2*p]});
            sel_rd(BCRF_ABS8, n[3:0]);
            chk("abs8", rv[7:0], regs[n]);
         end
      end
      u_cpu.wr(OFS_STATUS[3:0], 32'h0200);
      u_cpu.wr(OFS_NAMESEL[3:0], {25'h0, BCRF_ABS8, 4'h0});
      u_cpu.wr(OFS_NAMEDATA[3:0], {24'h0, ~regs[0]});
      u_cpu.wr(OFS_STATUS[3:0], 32'h0600);
      sel_rd(BCRF_ABS8, 4'h0);
      chk("bank6 r0", rv[7:0], regs[0]);
      $display("test swap and banks done");
      u_cpu.wr(OFS_SP[3:0], 32'h000008);
      d = $random(seed);
      u_cpu.wr(OFS_STACK[3:0], {24'h0, d[7:0]});
      u_cpu.wr(OFS_STACK[3:0], {24'h0, d[15:8]});
      u_cpu.rd(OFS_SP[3:0], rv);
      chk("sp", rv[23:0], 24'h000006);
      u_cpu.rd(OFS_STACK[3:0], rv);
      chk("pop", rv[7:0], d[15:8]);
      u_cpu.rd(OFS_STACK[3:0], rv);
      chk("pop", rv[7:0], d[7:0]);
      u_cpu.wr(OFS_STATUS[3:0], 32'h0500);
      u_cpu.wr(OFS_CTXSW[3:0], 32'h4);
      u_cpu.wr(OFS_STATUS[3:0], 32'h0100);
      u_cpu.wr(OFS_CTXSW[3:0], 32'h2);
      u_cpu.rd(OFS_STATUS[3:0], rv);
      chk("psw pop", rv[15:0], 16'h0500);
      u_cpu.rd(OFS_SP[3:0], rv);
      chk("sp", rv[23:0], 24'h000008);
      $display("test stack done");
      d = $random(seed);
      u_cpu.wr(OFS_PC[3:0], {12'h0, d[19:0]});
      u_cpu.wr(OFS_STATUS[3:0], 32'h0091);
      u_cpu.wr(OFS_CTXSW[3:0], 32'h0308);
      u_cpu.wr(OFS_STATUS[3:0], 32'h0391);
      sel_rd(BCRF_ABS16, 4'h2);
      chk("pc save", rv[15:0], d[15:0]);
      sel_rd(BCRF_ABS16, 4'h3);
      chk("psw save", rv[15:0], {d[19:16], 4'h0, 8'h91});
      $display("test context done");
      u_cpu.wr(OFS_CTRL[3:0], 32'h2);
      u_cpu.wr(OFS_RAMWIN[3:0], {8'h0, RAM_HI_BASE + 24'h000011});
      u_cpu.wr(OFS_RAMDATA[3:0], {24'h0, d[27:20]});
      u_cpu.rd(OFS_RAMDATA[3:0], rv);
      chk("ram high", rv[7:0], d[27:20]);
      u_cpu.wr(OFS_STATUS[3:0], 32'h0100);
      sel_rd(BCRF_ABS8, 4'h1);
      chk("alias name", rv[7:0], d[27:20]);
      u_cpu.wr(OFS_RAMWIN[3:0], {8'h0, RAM_LO_BASE + 24'h000011});
      u_cpu.rd(OFS_RAMDATA[3:0], rv);
      chk("ram low off", rv, 32'h0);
      u_cpu.rd(4'hC, rv);
      chk("unmapped", rv, 32'h0);
      $display("test memory alias done");
      stop_test();
   end
endmodule // tb_top
